// *** rtl/seq_volt_cfg.svh ***
// Purpose: constants for the sequence voltage stage
// Assumes: 20 MHz system clock, AHB-Lite register access
// Notes:   levels are in 0.01 percent of nominal voltage
`ifndef SEQ_VOLT_CFG_SVH
`define SEQ_VOLT_CFG_SVH
`define OFS_CTRL       12'h000
`define OFS_PICKUP     12'h004
`define OFS_BLOCK_LVL  12'h008
`define OFS_STATUS     12'h00c
`define OFS_INT_STAT   12'h010
`define OFS_INT_MASK   12'h014
`define OFS_MAG        12'h018
`define OFS_RATIO      12'h01c
`define PICKUP_MIN     16'h01f4
`define PICKUP_MAX     16'h3a98
`define PICKUP_RST     16'h2904
`define BLOCK_MAX      16'h1f40
`define BLOCK_RST      16'h01f4
`define HYST_OVER_PCT  8'h61
`define HYST_UNDER_PCT 8'h67
`define CYCLE_TIME_US  16'h0005
`define CLOCK_MHZ      16'h0014
`define CYCLE_COUNT    (`CYCLE_TIME_US * `CLOCK_MHZ)
`endif

// *** rtl/seq_volt_pkg.sv ***
// Purpose: types for the sequence voltage stage
// Assumes: nothing beyond the constants header
// Notes:   phasors are signed rectangular pairs
package seq_volt_pkg;
  typedef struct packed {
    logic signed [17:0] re;
    logic signed [17:0] im;
  } phasor_type;
  typedef enum logic [4:0] {
    MODE_ON = 5'h01, MODE_BLOCKED = 5'h02, MODE_TEST = 5'h04,
    MODE_TEST_BLOCKED = 5'h08, MODE_OFF = 5'h10
  } node_mode_type;
  typedef enum logic [3:0] {
    FORCE_NORMAL = 4'h1, FORCE_START = 4'h2, FORCE_TRIP = 4'h4, FORCE_BLOCKED = 4'h8
  } force_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, ST_CALC = 3'h2, ST_EVAL = 3'h4
  } phase_state_type;
  typedef struct packed {
    phase_state_type     state;
    logic [15:0]         cycle_cnt;
    logic signed [19:0]  sum_re;
    logic signed [19:0]  sum_im;
    logic [15:0]         magnitude;
    logic [15:0]         ratio;
    logic                pickup;
    logic                dead_block;
    logic                start;
    logic                trip;
    logic                blocked;
    logic [2:0]          int_stat;
    logic [2:0]          int_mask;
    logic                mag_sel_neg;
    logic                dir_under;
    node_mode_type       mode;
    force_type           force_sel;
    logic [15:0]         pickup_lvl;
    logic [15:0]         block_lvl;
    logic                hsel_d;
    logic                hwrite_d;
    logic [11:0]         haddr_d;
    logic [31:0]         hrdata;
    logic                irq;
  } state_type;
endpackage

// *** rtl/seq_volt_stage.sv ***
// Purpose: sequence voltage over/under stage with AHB-Lite settings
// Assumes: phasors already filtered to the fundamental, in 0.01 %Un
// Notes:   one evaluation per program cycle of CYCLE_COUNT plus two clocks
//          trip follows start directly; delay timers sit outside
//          hreadyout and hresp are tied: the slave never waits or errors
//          timing: IDLE counts CYCLE_COUNT clocks, CALC samples phasors,
//          EVAL samples block_in; outputs move at the edge after EVAL
//          forcing needs force_enable_in high, acts at next evaluation
//          group loads and bus writes share the same range checks
//          register map, byte offsets, one word each:
//            CTRL      [0] magnitude select, 1 is negative
//                      [1] direction, 1 is under
//                      [10:6] node operating mode, one-hot
//                      [14:11] force status, one-hot
//            PICKUP    [15:0] pick-up level
//            BLOCK_LVL [15:0] under-mode blocking level
//            STATUS    [0] start [1] trip [2] blocked
//                      [3] pick-up [4] dead block
//            INT_STAT  [2:0] start, trip, blocked rises
//                      a read clears, a new event wins
//            INT_MASK  [2:0] enables for INT_STAT
//            MAG       [15:0] supervised magnitude
//            RATIO     [15:0] magnitude over pick-up, hundredths
//          unmapped offsets read zero, writes there are lost
//          refused levels leave the old value in place
//          magnitude error of the approximation is a few percent
//          levels: one LSB is 0.01 percent of nominal
//          all state sits in one struct, registered at one edge
//          inputs are taken as synchronous to sys_clk_in
//          reset is synchronous and active low
// Functional notes
// - positive sequence: L1 + aL2 + a2L3, over three
// - negative sequence: L1 + a2L2 + aL3, over three
// - only fundamental phasors feed the calculation
// - magnitude select, positive by default
// - over or under direction, over default
// - pick-up on crossing; ratio continuously computed
// - over mode releases below 97 percent
// - under mode releases above 103 percent
// - pick-up 5 to 150 percent, default 105
// - blocking level 0 to 80, default 5
// - after dead network, block until voltages recover
// - blocking level zero disables dead blocking
// - node mode: on/blocked/test/test-blocked/off
// - force status only with global forcing enable
// - mode, force, select unaffected by group change
// - group pick-up values apply while running
// - block input at pick-up gives blocked
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "seq_volt_cfg.svh"
module seq_volt_stage
  import seq_volt_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // AHB-Lite slave port, word registers only
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hsel,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // fundamental phasors from the measurement front end
  input  wire phasor_type  phase_one_voltage_in,
  input  wire phasor_type  phase_two_voltage_in,
  input  wire phasor_type  phase_three_voltage_in,
  // blocking matrix, global forcing and setting group
  input  wire logic        block_in,
  input  wire logic        force_enable_in,
  input  wire logic        group_load_in,
  input  wire logic [15:0] group_pickup_in,
  input  wire logic [15:0] group_block_in,
  // stage outputs, from the state register
  output logic             start_out,
  output logic             trip_out,
  output logic             blocked_out,
  output logic             irq_out
);
  // cos/sin 120 deg in Q1.15; 240 deg is the same cosine with
  // the sine negated, so one pair serves both rotations
  localparam logic signed [17:0] COS120 = 18'sh3c000;
  localparam logic signed [17:0] SIN120 = 18'sh06ed9;

  // every flip-flop of the stage lives in this struct
  state_type cur_reg;
  state_type cur_next;

  // rotate a phasor by +120 (neg=0) or +240 (neg=1) degrees
  // fractional bits are truncated: at most one LSB low per product,
  // far below the three percent hysteresis
  function automatic phasor_type rotate(input phasor_type p, input logic neg);
    logic signed [35:0] re_p;
    logic signed [35:0] im_p;
    logic signed [17:0] s;
    phasor_type r;
    s    = neg ? -SIN120 : SIN120;
    // full-width complex product; bits [32:15] drop the Q1.15
    // scaling and keep the phasor's own 18-bit range
    re_p = p.re * COS120 - p.im * s;
    im_p = p.re * s + p.im * COS120;
    r.re = re_p[32:15];
    r.im = im_p[32:15];
    return r;
  endfunction

  // magnitude approximation max + 3/8 min, good to about 7 percent
  // worst near 21 degrees, where min is 3/8 of max; values on the real axis come out exact
  function automatic logic [15:0] mag_approx(input logic signed [19:0] re,
                                              input logic signed [19:0] im);
    logic [19:0] a;
    logic [19:0] b;
    logic [19:0] hi;
    logic [19:0] lo;
    logic [21:0] m;
    // fold both legs into the first quadrant
    a  = re[19] ? 20'(-re) : 20'(re);
    b  = im[19] ? 20'(-im) : 20'(im);
    // order the legs so that hi is never below lo
    hi = (a > b) ? a : b;
    lo = (a > b) ? b : a;
    // no square root: larger leg plus 3/8 of the smaller
    m  = 22'(hi) + 22'((lo * 3) >> 3);
    // one-third factor of the components, then saturate
    m  = 22'(m / 3);
    return (m > 22'h00ffff) ? 16'hffff : m[15:0];
  endfunction

  // address phase taken when selected, ready and NONSEQ or SEQ;
  // hsize is not decoded, since only whole aligned words
  // are served
  wire logic       wr_take = hsel & hready & htrans[1] & hwrite;
  wire logic       rd_take = hsel & hready & htrans[1] & ~hwrite;

  // next state: sequencer, sequence calculation, pick-up and
  // blocking, interrupt flags and register file all fill one
  // copy of the state, so every output moves at one edge
  always_comb begin
    phasor_type    r2;
    phasor_type    r3;
    logic [31:0]   pick_ext;
    logic [31:0]   mag_ext;
    logic          over_hit;
    logic          under_hit;
    logic          rel_over;
    logic          rel_under;
    logic          pickup_n;
    logic          stage_on;
    logic          start_raw;
    logic [2:0]    ev;

    // hold everything; only the branches below move state
    cur_next = cur_reg;
    r2 = '0;
    r3 = '0;
    // widen first so that level times 103 cannot wrap
    pick_ext = 32'(cur_reg.pickup_lvl);
    mag_ext  = 32'(cur_reg.magnitude);
    // crossing and release tests, in hundredths of the level
    over_hit  = mag_ext * 32'h64 > pick_ext * 32'h64;
    under_hit = mag_ext * 32'h64 < pick_ext * 32'h64;
    rel_over  = mag_ext * 32'h64 < pick_ext * 32'(`HYST_OVER_PCT);
    rel_under = mag_ext * 32'h64 > pick_ext * 32'(`HYST_UNDER_PCT);
    // pick-up keeps its state between crossing and release
    pickup_n  = cur_reg.pickup;
    stage_on  = 1'b0;
    start_raw = 1'b0;
    ev = 3'h0;

    // program cycle sequencer
    // IDLE, CALC, EVAL, IDLE: one pass is CYCLE_COUNT plus two
    case (cur_reg.state)
      ST_IDLE: begin
        // count out the idle part of the program cycle
        cur_next.cycle_cnt = cur_reg.cycle_cnt + 16'h0001;
        if (cur_reg.cycle_cnt >= 16'(`CYCLE_COUNT) - 16'h0001) begin
          // last idle clock: the next one samples the phasors
          cur_next.cycle_cnt = 16'h0000;
          cur_next.state = ST_CALC;
        end
      end

      ST_CALC: begin
        // symmetric components from fundamental phasors
        // the select bit swaps the rotations of phases two and
        // three: +120/+240 is positive, +240/+120 negative
        // phase one enters unrotated
        r2 = rotate(phase_two_voltage_in, cur_reg.mag_sel_neg);
        r3 = rotate(phase_three_voltage_in, ~cur_reg.mag_sel_neg);
        cur_next.sum_re = 20'(phase_one_voltage_in.re) + 20'(r2.re) + 20'(r3.re);
        cur_next.sum_im = 20'(phase_one_voltage_in.im) + 20'(r2.im) + 20'(r3.im);
        // the sum is three sequence phasors; mag_approx divides
        cur_next.magnitude = mag_approx(cur_next.sum_re, cur_next.sum_im);
        cur_next.state = ST_EVAL;
      end

      ST_EVAL: begin
        // ratio magnitude/pick-up in 0.01 units
        // a zero level cannot be written; the guard is spare
        cur_next.ratio = (cur_reg.pickup_lvl == 16'h0000) ? 16'hffff :
                         16'((mag_ext * 32'h64) / pick_ext);
        // over: cross above the level, release below 97 percent
        // under: cross below the level, release above 103 percent
        // the gap keeps a hovering magnitude from chattering
        if (!cur_reg.dir_under) begin
          if (over_hit) pickup_n = 1'b1;
          else if (rel_over) pickup_n = 1'b0;
        end else begin
          if (under_hit) pickup_n = 1'b1;
          else if (rel_under) pickup_n = 1'b0;
        end
        cur_next.pickup = pickup_n;

        // dead network blocking in under mode
        // latched below the blocking level, cleared once the
        // magnitude is above the pick-up level; zero disables it
        if (!cur_reg.dir_under || cur_reg.block_lvl == 16'h0000)
          cur_next.dead_block = 1'b0;
        else if (cur_reg.magnitude < cur_reg.block_lvl)
          cur_next.dead_block = 1'b1;
        else if (cur_reg.magnitude > cur_reg.pickup_lvl)
          cur_next.dead_block = 1'b0;

        // only on and test evaluate; the other modes stay quiet
        stage_on  = (cur_reg.mode == MODE_ON) || (cur_reg.mode == MODE_TEST);
        start_raw = pickup_n & ~cur_next.dead_block & stage_on;
        // block input or dead network turn pick-up into blocked
        cur_next.start   = start_raw & ~block_in;
        cur_next.blocked = pickup_n & stage_on & (block_in | cur_next.dead_block);
        // delay timers are outside, so trip follows start
        cur_next.trip    = cur_next.start;

        // forcing overrides the outputs, only while enabled
        if (force_enable_in) begin
          case (cur_reg.force_sel)
            FORCE_START: begin
              cur_next.start   = 1'b1;
              cur_next.trip    = 1'b0;
              cur_next.blocked = 1'b0;
            end
            FORCE_TRIP: begin
              cur_next.start   = 1'b1;
              cur_next.trip    = 1'b1;
              cur_next.blocked = 1'b0;
            end
            FORCE_BLOCKED: begin
              cur_next.start   = 1'b0;
              cur_next.trip    = 1'b0;
              cur_next.blocked = 1'b1;
            end
            default: ;
          endcase
        end

        // rising edges of the three outputs are interrupt events
        ev = {cur_next.blocked & ~cur_reg.blocked, cur_next.trip & ~cur_reg.trip,
              cur_next.start & ~cur_reg.start};
        cur_next.state = ST_IDLE;
      end

      // an illegal code returns to a clean program cycle
      default: cur_next.state = ST_IDLE;
    endcase

    // pick-up parameters from the active setting group
    // taken in any sequencer state, used from the next
    // evaluation on without stopping the stage
    if (group_load_in) begin
      if (group_pickup_in >= `PICKUP_MIN && group_pickup_in <= `PICKUP_MAX)
        cur_next.pickup_lvl = group_pickup_in;
      if (group_block_in <= `BLOCK_MAX)
        cur_next.block_lvl = group_block_in;
    end

    // bus address phase capture
    // the data phase follows, when hwdata is valid
    cur_next.hsel_d   = rd_take | wr_take;
    cur_next.hwrite_d = wr_take;
    cur_next.haddr_d  = haddr[11:0];

    // read data; interrupt status read clears sticky bits, new events win
    // set at the address edge, so it stands for the data phase
    cur_next.hrdata = 32'h0;
    if (rd_take) begin
      case (haddr[11:0])
        // control word, unused bits zero
        `OFS_CTRL:      cur_next.hrdata = {17'h0, cur_reg.force_sel, cur_reg.mode,
                                           4'h0, cur_reg.dir_under, cur_reg.mag_sel_neg};
        `OFS_PICKUP:    cur_next.hrdata = {16'h0, cur_reg.pickup_lvl};
        `OFS_BLOCK_LVL: cur_next.hrdata = {16'h0, cur_reg.block_lvl};
        // live state of the stage, read only
        `OFS_STATUS:    cur_next.hrdata = {27'h0, cur_reg.dead_block, cur_reg.pickup,
                                           cur_reg.blocked, cur_reg.trip, cur_reg.start};
        `OFS_INT_STAT:  cur_next.hrdata = {29'h0, cur_reg.int_stat};
        `OFS_INT_MASK:  cur_next.hrdata = {29'h0, cur_reg.int_mask};
        // values of the last evaluation
        `OFS_MAG:       cur_next.hrdata = {16'h0, cur_reg.magnitude};
        `OFS_RATIO:     cur_next.hrdata = {16'h0, cur_reg.ratio};
        // unmapped offsets read as zero
        default:        cur_next.hrdata = 32'h0;
      endcase
    end

    // sticky interrupt flags; a read and a new event in one
    // cycle keep the event
    cur_next.int_stat = cur_reg.int_stat;
    if (rd_take && haddr[11:0] == `OFS_INT_STAT)
      cur_next.int_stat = 3'h0;
    cur_next.int_stat = cur_next.int_stat | ev;

    // register writes in data phase; static settings live only here
    // a write in the cycle of a group load wins, being later
    if (cur_reg.hwrite_d) begin
      case (cur_reg.haddr_d)
        `OFS_CTRL: begin
          cur_next.mag_sel_neg = hwdata[0];
          cur_next.dir_under   = hwdata[1];
          // undefined mode or force codes leave the setting as is
          if (hwdata[10:6] inside {MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED,
                                   MODE_OFF})
            cur_next.mode = node_mode_type'(hwdata[10:6]);
          if (hwdata[14:11] inside {FORCE_NORMAL, FORCE_START, FORCE_TRIP, FORCE_BLOCKED})
            cur_next.force_sel = force_type'(hwdata[14:11]);
        end
        // out-of-range levels are refused, the old value kept
        `OFS_PICKUP:
          if (hwdata[15:0] >= `PICKUP_MIN && hwdata[15:0] <= `PICKUP_MAX)
            cur_next.pickup_lvl = hwdata[15:0];
        `OFS_BLOCK_LVL:
          if (hwdata[15:0] <= `BLOCK_MAX)
            cur_next.block_lvl = hwdata[15:0];
        // mask bits enable the matching interrupt flags
        `OFS_INT_MASK: cur_next.int_mask = hwdata[2:0];
        default: ;
      endcase
    end

    // level interrupt while any unmasked flag is set
    cur_next.irq = |(cur_next.int_stat & cur_next.int_mask);
  end

  // single state register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      // settings to defaults; flags, outputs, bus state clear
      cur_reg             <= '0;
      cur_reg.state       <= ST_IDLE;
      cur_reg.mode        <= MODE_ON;
      cur_reg.force_sel   <= FORCE_NORMAL;
      cur_reg.pickup_lvl  <= `PICKUP_RST;
      cur_reg.block_lvl   <= `BLOCK_RST;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // outputs from the state register; the bus never waits
  assign hrdata      = cur_reg.hrdata;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign start_out   = cur_reg.start;
  assign trip_out    = cur_reg.trip;
  assign blocked_out = cur_reg.blocked;
  assign irq_out     = cur_reg.irq;
endmodule

// *** test/front_end_model.sv ***
// Purpose: measurement front end model feeding fundamental phasors
// Assumes: level in 0.01 %Un, phase order one-two-three
// Notes:   unbalanced mode puts three times the level on phase one only
`timescale 1ns/10ps
module front_end_model
  import seq_volt_pkg::*;
(
  input  wire logic [15:0] level_in,
  input  wire logic        sys_clk_in,
  input  wire logic        balanced_in,
  output phasor_type       ph1_out,
  output phasor_type       ph2_out,
  output phasor_type       ph3_out
);
  int h;
  int s;
  // phasors move just after an edge; no harmonic is ever produced
  always @(posedge sys_clk_in) begin
    h = level_in / 2;
    s = level_in * 866 / 1000;
    ph1_out <= balanced_in ? {18'(level_in), 18'h0} : {18'(3 * level_in), 18'h0};
    ph2_out <= balanced_in ? {18'(-h), 18'(-s)} : '0;
    ph3_out <= balanced_in ? {18'(-h), 18'(s)} : '0;
  end
endmodule

// *** test/seq_volt_sva.sv ***
// Purpose: port assertions for the sequence voltage stage
// Assumes: one clock, synchronous active-low reset
// Notes:   forced outputs are left out of the evaluated-output checks
`timescale 1ns/10ps
module seq_volt_sva (
  input wire logic        sys_clk_in,
  input wire logic        rst_n_in,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        block_in,
  input wire logic        force_enable_in,
  input wire logic        start_out,
  input wire logic        trip_out,
  input wire logic        blocked_out
);
  logic       rq;
  logic [2:0] outs;
  logic [7:0] gap_reg;
  // read request and output bundle
  assign rq = hsel && hready && htrans[1] && !hwrite;
  assign outs = {blocked_out, trip_out, start_out};
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // cycles since outputs last moved, saturating
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) gap_reg <= 8'hff;
    else if ($changed(outs)) gap_reg <= 8'h00;
    else if (gap_reg != 8'hff) gap_reg <= gap_reg + 8'h01;
  end
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_RDATA_IDLE: assert property (!$past(rq) |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  AST_STATUS_READ: assert property (rq && haddr[11:0] == 12'h00c
    |=> hrdata[2:0] == $past(outs)) else $error("status read disagrees with outputs");
  AST_TRIP_START: assert property (!force_enable_in |-> trip_out == start_out)
    else $error("trip differs from start");
  AST_NOT_BOTH: assert property (!force_enable_in |-> !(start_out && blocked_out))
    else $error("start and blocked together");
  AST_START_FREE: assert property ($rose(start_out) && !force_enable_in |-> !$past(block_in))
    else $error("start raised while block input active");
  AST_ONE_UPDATE: assert property ($changed(outs) && !force_enable_in
    |-> gap_reg >= 8'd100) else $error("outputs moved twice in one program cycle");
  AST_UNMAPPED: assert property (rq && haddr[11:0] >= 12'h020 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  cover property ($rose(start_out));
  cover property ($rose(blocked_out));
  cover property (rq && haddr[11:0] == 12'h00c);
endmodule
bind seq_volt_stage seq_volt_sva sva (.*);

// *** test/testbench.sv ***
// Purpose: self-checking bench for the sequence voltage stage
// Assumes: zero wait AHB-Lite slave, program cycle of 102 clocks
// Notes:   each level step waits two program cycles before checking
`timescale 1ns/10ps
`include "seq_volt_cfg.svh"
module testbench;
  import seq_volt_pkg::*;
  logic        clk = 0, rst_n = 0, hwrite = 0, hsel = 0, blk = 0, fen = 0, gld = 0, bal = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0]  htrans = '0;
  logic [15:0] gpk = '0, lvl = '0;
  logic        hready, hresp, st, tr, bo, irq;
  phasor_type  p1, p2, p3;
  int          miscompares = 0, comparisons = 0;
  always #25 clk = ~clk;
  front_end_model fe (.sys_clk_in(clk), .level_in(lvl), .balanced_in(bal),
    .ph1_out(p1), .ph2_out(p2), .ph3_out(p3));
  seq_volt_stage dut (.sys_clk_in(clk), .rst_n_in(rst_n), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .phase_one_voltage_in(p1),
    .phase_two_voltage_in(p2), .phase_three_voltage_in(p3), .block_in(blk),
    .force_enable_in(fen), .group_load_in(gld), .group_pickup_in(gpk),
    .group_block_in(16'h01f4), .start_out(st), .trip_out(tr), .blocked_out(bo),
    .irq_out(irq));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // one single word transfer, held until hready is seen high
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 20'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk($sformatf("register %h", a), e, q);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic go(input logic [15:0] v);
    lvl <= v;
    repeat (210) @(posedge clk);
  endtask
  task automatic step(input logic [15:0] v, input logic [2:0] e);
    go(v);
    chk("outputs", {29'h0, e}, {29'h0, bo, tr, st});
  endtask
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask
  task automatic end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    end_sim;
  end
  initial begin
    node_mode_type md[4] = '{MODE_OFF, MODE_BLOCKED, MODE_TEST_BLOCKED, MODE_TEST};
    force_type     fc[4] = '{FORCE_NORMAL, FORCE_START, FORCE_TRIP, FORCE_BLOCKED};
    logic [2:0]    mx[4] = '{3'b000, 3'b000, 3'b000, 3'b011};
    logic [2:0]    fx[4] = '{3'b000, 3'b001, 3'b011, 3'b100};
    repeat (5) @(posedge clk);
    rst_n <= 1;
    rd(`OFS_CTRL, 32'h0840);
    rd(`OFS_PICKUP, 32'h2904);
    rd(`OFS_BLOCK_LVL, 32'h01f4);
    rd(`OFS_INT_MASK, 32'h0);
    rd(12'h020, 32'h0);
    wr(`OFS_PICKUP, 32'h01f3);
    rd(`OFS_PICKUP, 32'h2904);
    wr(`OFS_BLOCK_LVL, 32'h1f41);
    rd(`OFS_BLOCK_LVL, 32'h01f4);
    wr(`OFS_PICKUP, 32'h1388);
    done("reset and ranges");
    wr(`OFS_INT_MASK, 32'h1);
    step(16'd6000, 3'b011);
    chk("irq", 32'h1, {31'h0, irq});
    rd(`OFS_MAG, 32'h1770);
    rd(`OFS_RATIO, 32'h78);
    rd(`OFS_STATUS, 32'h0b);
    rd(`OFS_INT_STAT, 32'h3);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    step(16'd4900, 3'b011);
    step(16'd4800, 3'b000);
    blk <= 1;
    step(16'd6000, 3'b100);
    blk <= 0;
    step(16'd4800, 3'b000);
    done("over mode and blocking input");
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_CTRL, {17'h0, FORCE_NORMAL, md[i], 6'h0});
      step(16'd6000, mx[i]);
      step(16'd4800, 3'b000);
    end
    wr(`OFS_CTRL, 32'h0840);
    bal <= 1;
    step(16'd6000, 3'b011);
    wr(`OFS_CTRL, 32'h0841);
    step(16'd6000, 3'b000);
    done("modes and magnitude select");
    wr(`OFS_CTRL, 32'h0842);
    bal <= 0;
    step(16'd4800, 3'b011);
    step(16'd5100, 3'b011);
    step(16'd5200, 3'b000);
    go(16'd300);
    chk("trip", 32'h0, {31'h0, tr});
    go(16'd4900);
    chk("trip", 32'h0, {31'h0, tr});
    step(16'd5200, 3'b000);
    step(16'd4900, 3'b011);
    step(16'd5200, 3'b000);
    wr(`OFS_BLOCK_LVL, 32'h0);
    step(16'd300, 3'b011);
    done("under mode and dead network");
    gpk <= 16'h1b58;
    gld <= 1;
    @(posedge clk);
    gld <= 0;
    rd(`OFS_PICKUP, 32'h1b58);
    rd(`OFS_CTRL, 32'h0842);
    step(16'd6900, 3'b011);
    step(16'd7300, 3'b000);
    wr(`OFS_CTRL, 32'h2042);
    step(16'd7300, 3'b000);
    fen <= 1;
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_CTRL, {17'h0, fc[i], 5'h01, 4'h0, 2'h2});
      step(16'd7300, fx[i]);
    end
    done("setting group and forcing");
    end_sim;
  end
endmodule
